// file: logic/aio_logic.sv
// advanced i/o function blocks: gates, door interlock/man-trap, counter, exit door, one-shot
// Operation
// [RQ1] and output high only while every enabled input is high
// [RQ2] xor output high when enabled inputs differ, low when all equal
// [RQ3] nand output high when any enabled input is low
// [RQ4] interlock: idle unlocked; opened door stays low, others go high until closed
// [RQ5] interlock and man-trap handle at most five doors, one input and output each
// [RQ6] while one interlocked door is open, other doors stay locked
// [RQ7] door group has enable and activate-all inputs, each forceable by configuration
// [RQ8] man-trap: idle locked; reader grant unlocks that door, others held locked
// [RQ9] while one man-trap door is unlocked, other grants are ignored
// [RQ10] counter adds one on each rising up-count edge
// [RQ11] counter subtracts one on each rising down-count edge
// [RQ12] rising edge on counter reset clears count to zero
// [RQ13] nonzero output high whenever count is not zero
// [RQ14] limit output high whenever count reaches or exceeds maximum
// [RQ15] counter maximum 0 to 65535 and preload value are configurable
// [RQ16] exit request rising edge drives strike high for strike duration
// [RQ17] lock/unlock input holds strike high while active
// [RQ18] exit request during forced strike leaves strike unchanged
// [RQ19] contact held past alarm delay raises forced-open until contact drops
// [RQ20] contact pulse shorter than alarm delay is ignored
// [RQ21] held-open rises after strike time then door-open time expire
// [RQ22] one-shot output high for fixed duration on input rising edge
// [RQ23] all durations count ticks of a common timebase from the clock
// [RQ24] counter saturates at zero and at 65535
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module aio_logic #(
   parameter int N_GATE = 7,
   parameter int N_DOOR = 5,
   parameter int TICK_DIV_RST = aio_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [N_GATE-1:0] gate_in,
   output logic and_out,
   output logic xor_out,
   output logic nand_out,
   input wire logic [N_DOOR-1:0] door_in,
   input wire logic door_enable,
   input wire logic door_all,
   output logic [N_DOOR-1:0] door_lock,
   input wire logic cnt_up,
   input wire logic cnt_down,
   input wire logic cnt_clear,
   output logic cnt_nonzero,
   output logic cnt_at_max,
   input wire logic exit_request,
   input wire logic exit_hold,
   input wire logic exit_contact,
   output logic exit_strike,
   output logic exit_forced,
   output logic exit_held,
   input wire logic pulse_in,
   output logic pulse_out
);
   typedef enum logic [1:0] {EX_IDLE, EX_STRIKE, EX_OPEN, EX_HELD} exit_state_t;

   // config registers
   logic [31:0] gate_cfg;
   logic [31:0] door_cfg;
   logic [15:0] cnt_max;
   logic [15:0] cnt_preload;
   logic [15:0] strike_ticks;
   logic [15:0] alarm_ticks;
   logic [15:0] held_ticks;
   logic [15:0] pulse_ticks;
   logic [31:0] tick_div;
   logic load_req;
   // state
   logic [31:0] tick_cnt;
   logic tick;
   logic [N_DOOR-1:0] door_q;
   logic [N_DOOR-1:0] owner;
   logic [15:0] count;
   logic up_q, down_q, clr_q, req_q, contact_q, pin_q;
   exit_state_t ex_state;
   logic [15:0] ex_timer;
   logic [15:0] alarm_timer;
   logic [15:0] pulse_timer;

   // byte-lane merge, used by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // 16-bit registers keep only the low half, upper lanes are dropped on purpose
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = merge({16'h0000, old}, wd, be);
      return r[15:0];
   endfunction

   // one-cycle answer: waitrequest low in the cycle after a request is seen
   wire bus_req = (avs_read | avs_write) & avs_waitrequest;
   wire wr_go = avs_write & ~avs_waitrequest;
   wire wr_gate = wr_go && avs_address == aio_pkg::OFF_GATE_CFG;
   wire wr_door = wr_go && avs_address == aio_pkg::OFF_DOOR_CFG;
   wire wr_max = wr_go && avs_address == aio_pkg::OFF_CNT_MAX;
   wire wr_pre = wr_go && avs_address == aio_pkg::OFF_CNT_PRELOAD;
   wire wr_ctrl = wr_go && avs_address == aio_pkg::OFF_CNT_CTRL;
   wire wr_strike = wr_go && avs_address == aio_pkg::OFF_STRIKE_TICKS;
   wire wr_alarm = wr_go && avs_address == aio_pkg::OFF_ALARM_TICKS;
   wire wr_held = wr_go && avs_address == aio_pkg::OFF_HELD_TICKS;
   wire wr_pulse = wr_go && avs_address == aio_pkg::OFF_PULSE_TICKS;
   wire wr_div = wr_go && avs_address == aio_pkg::OFF_TICK_DIV;
   wire [31:0] wd_m = avs_writedata;

   // read mux, unmapped addresses read zero
   logic [31:0] next_readdata;
   always_comb begin
      unique case (avs_address)
         aio_pkg::OFF_GATE_CFG: next_readdata = gate_cfg;
         aio_pkg::OFF_DOOR_CFG: next_readdata = door_cfg;
         aio_pkg::OFF_CNT_MAX: next_readdata = {16'h0000, cnt_max};
         aio_pkg::OFF_CNT_PRELOAD: next_readdata = {16'h0000, cnt_preload};
         aio_pkg::OFF_STRIKE_TICKS: next_readdata = {16'h0000, strike_ticks};
         aio_pkg::OFF_ALARM_TICKS: next_readdata = {16'h0000, alarm_ticks};
         aio_pkg::OFF_HELD_TICKS: next_readdata = {16'h0000, held_ticks};
         aio_pkg::OFF_PULSE_TICKS: next_readdata = {16'h0000, pulse_ticks};
         aio_pkg::OFF_TICK_DIV: next_readdata = tick_div;
         aio_pkg::OFF_STATUS: next_readdata = {16'h0000, 3'b000, pulse_out, exit_held,
            exit_forced, exit_strike, cnt_at_max, cnt_nonzero, xor_out, nand_out, and_out,
            ex_state == EX_IDLE, door_lock[2:0]};
         aio_pkg::OFF_COUNT: next_readdata = {16'h0000, count};
         default: next_readdata = aio_pkg::UNMAPPED_READ;
      endcase
   end

   // bus handshake
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~bus_req;
         if (bus_req && avs_read) begin
            avs_readdata <= next_readdata;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_cfg <= aio_pkg::GATE_CFG_RST;
         door_cfg <= aio_pkg::DOOR_CFG_RST;
         cnt_max <= aio_pkg::CNT_MAX_RST;
         cnt_preload <= aio_pkg::CNT_PRELOAD_RST;
         strike_ticks <= aio_pkg::DURATION_RST;
         alarm_ticks <= aio_pkg::DURATION_RST;
         held_ticks <= aio_pkg::DURATION_RST;
         pulse_ticks <= aio_pkg::DURATION_RST;
         tick_div <= 32'(TICK_DIV_RST);
      end else begin
         if (wr_gate) begin
            gate_cfg <= merge(gate_cfg, wd_m, avs_byteenable);
         end
         if (wr_door) begin
            door_cfg <= merge(door_cfg, wd_m, avs_byteenable);
         end
         if (wr_max) begin
            cnt_max <= merge16(cnt_max, wd_m, avs_byteenable); // [RQ15]
         end
         if (wr_pre) begin
            cnt_preload <= merge16(cnt_preload, wd_m, avs_byteenable);
         end
         if (wr_strike) begin
            strike_ticks <= merge16(strike_ticks, wd_m, avs_byteenable);
         end
         if (wr_alarm) begin
            alarm_ticks <= merge16(alarm_ticks, wd_m, avs_byteenable);
         end
         if (wr_held) begin
            held_ticks <= merge16(held_ticks, wd_m, avs_byteenable);
         end
         if (wr_pulse) begin
            pulse_ticks <= merge16(pulse_ticks, wd_m, avs_byteenable);
         end
         if (wr_div) begin
            tick_div <= merge(tick_div, wd_m, avs_byteenable);
         end
      end
   end
   assign load_req = wr_ctrl & avs_byteenable[0] & wd_m[aio_pkg::CNT_CTRL_LOAD_BIT];

   // common timebase, one-cycle tick every tick_div cycles
   // wrap test shared by the tick flop and the divider counter
   wire [31:0] tick_inc = tick_cnt + 32'h0000_0001;
   wire tick_wrap = tick_inc >= tick_div;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         tick <= tick_wrap; // [RQ23]
         tick_cnt <= tick_wrap ? 32'h0000_0000 : tick_inc;
      end
   end

   // gates: gate_cfg[6:0] selects inputs; unselected inputs are neutral
   wire [N_GATE-1:0] gate_en = gate_cfg[N_GATE-1:0];
   wire [N_GATE-1:0] gate_act = gate_in & gate_en;
   wire all_high = ((gate_in | ~gate_en) == {N_GATE{1'b1}}) && (gate_en != '0);
   wire all_low = (gate_act == '0);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         and_out <= 1'b0;
         xor_out <= 1'b0;
         nand_out <= 1'b0;
      end else begin
         and_out <= all_high; // [RQ1]
         xor_out <= (gate_en != '0) & ~all_high & ~all_low; // [RQ2]
         nand_out <= (gate_en != '0) & ~all_high; // [RQ3]
      end
   end

   // door group: mode 0 interlock (contacts), mode 1 man-trap (reader grants)
   wire mantrap = door_cfg[aio_pkg::DOOR_CFG_MODE_BIT];
   wire grp_en = door_cfg[aio_pkg::DOOR_CFG_ENABLE_BIT] | door_enable; // [RQ7]
   wire grp_all = door_cfg[aio_pkg::DOOR_CFG_ALL_BIT] | door_all; // [RQ7]
   wire [N_DOOR-1:0] door_used = door_cfg[aio_pkg::DOOR_CFG_MASK_LSB +: N_DOOR]; // [RQ5]
   wire [N_DOOR-1:0] door_rise = door_in & ~door_q & door_used;
   // lowest-numbered door wins simultaneous edges
   wire [N_DOOR-1:0] first_rise = door_rise & (~door_rise + N_DOOR'(1));
   // interlock owner releases on contact close; man-trap owner on grant drop
   wire owner_done = (owner & door_in) == '0;
   wire [N_DOOR-1:0] next_owner = !grp_en ? '0
      : (owner != '0) ? (owner_done ? '0 : owner) // [RQ6] [RQ9]
      : first_rise; // [RQ4] [RQ8]
   wire [N_DOOR-1:0] idle_lock = mantrap ? door_used : '0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         door_q <= '0;
         owner <= '0;
         door_lock <= '0;
      end else begin
         door_q <= door_in;
         owner <= next_owner;
         door_lock <= grp_all ? door_used
            : (next_owner != '0) ? (door_used & ~next_owner) : idle_lock; // [RQ4] [RQ8]
      end
   end

   // up/down counter with saturation
   wire up_e = cnt_up & ~up_q;
   wire down_e = cnt_down & ~down_q;
   wire clr_e = cnt_clear & ~clr_q;
   logic [15:0] next_count;
   always_comb begin
      next_count = count;
      if (clr_e) begin
         next_count = 16'h0000; // [RQ12]
      end else if (load_req) begin
         next_count = cnt_preload; // [RQ15]
      end else if (up_e && !down_e && count != aio_pkg::CNT_TOP) begin
         next_count = count + 16'h0001; // [RQ10] [RQ24]
      end else if (down_e && !up_e && count != 16'h0000) begin
         next_count = count - 16'h0001; // [RQ11] [RQ24]
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {up_q, down_q, clr_q} <= 3'b000;
         count <= aio_pkg::CNT_PRELOAD_RST;
         cnt_nonzero <= 1'b0;
         cnt_at_max <= 1'b0;
      end else begin
         {up_q, down_q, clr_q} <= {cnt_up, cnt_down, cnt_clear};
         count <= next_count;
         cnt_nonzero <= next_count != 16'h0000; // [RQ13]
         cnt_at_max <= next_count >= cnt_max; // [RQ14]
      end
   end

   // exit door: strike timer then door-open timer ahead of held-open alarm
   wire req_e = exit_request & ~req_q;
   wire ex_expired = tick && ex_timer <= 16'h0001;
   exit_state_t next_ex;
   logic [15:0] next_ex_timer;
   always_comb begin
      next_ex = ex_state;
      next_ex_timer = (tick && ex_timer != 16'h0000) ? ex_timer - 16'h0001 : ex_timer;
      unique case (ex_state)
         EX_IDLE: begin
            if (req_e && !exit_hold) begin // [RQ16] [RQ18]
               next_ex = EX_STRIKE;
               next_ex_timer = strike_ticks;
            end
         end
         EX_STRIKE: begin
            if (ex_expired) begin
               next_ex = EX_OPEN;
               next_ex_timer = held_ticks;
            end
         end
         EX_OPEN: begin
            if (!exit_contact && ex_expired) begin
               next_ex = EX_IDLE;
            end else if (ex_expired) begin
               next_ex = EX_HELD; // [RQ21]
            end
         end
         EX_HELD: begin
            if (!exit_contact) begin
               next_ex = EX_IDLE;
            end
         end
      endcase
   end
   // forced-open delay counts only while contact stays high
   wire contact_rise = exit_contact & ~contact_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {req_q, contact_q} <= 2'b00;
         ex_state <= EX_IDLE;
         ex_timer <= 16'h0000;
         alarm_timer <= 16'h0000;
         exit_strike <= 1'b0;
         exit_forced <= 1'b0;
         exit_held <= 1'b0;
      end else begin
         {req_q, contact_q} <= {exit_request, exit_contact};
         ex_state <= next_ex;
         ex_timer <= next_ex_timer;
         exit_strike <= exit_hold | (next_ex == EX_STRIKE); // [RQ16] [RQ17]
         exit_held <= next_ex == EX_HELD; // [RQ21]
         if (!exit_contact) begin
            alarm_timer <= 16'h0000; // [RQ20]
            exit_forced <= 1'b0;
         end else if (contact_rise) begin
            alarm_timer <= alarm_ticks;
         end else if (tick && alarm_timer != 16'h0000) begin
            alarm_timer <= alarm_timer - 16'h0001;
            if (alarm_timer == 16'h0001) exit_forced <= 1'b1; // [RQ19]
         end
      end
   end

   // one-shot: retrigger ignored while running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q <= 1'b0;
         pulse_timer <= 16'h0000;
         pulse_out <= 1'b0;
      end else begin
         pin_q <= pulse_in;
         if (pulse_in && !pin_q && pulse_timer == 16'h0000) begin
            pulse_timer <= pulse_ticks; // [RQ22]
            pulse_out <= pulse_ticks != 16'h0000;
         end else if (tick && pulse_timer != 16'h0000) begin
            pulse_timer <= pulse_timer - 16'h0001; // [RQ23]
            pulse_out <= pulse_timer != 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// file: logic/aio_pkg.sv
// package: register map, reset values and timing constants for the advanced i/o block
package aio_pkg;
   // word offsets on the avalon-mm slave (byte addresses)
   localparam logic [5:0] OFF_GATE_CFG = 6'h00;
   localparam logic [5:0] OFF_DOOR_CFG = 6'h04;
   localparam logic [5:0] OFF_CNT_MAX = 6'h08;
   localparam logic [5:0] OFF_CNT_PRELOAD = 6'h0C;
   localparam logic [5:0] OFF_CNT_CTRL = 6'h10;
   localparam logic [5:0] OFF_STRIKE_TICKS = 6'h14;
   localparam logic [5:0] OFF_ALARM_TICKS = 6'h18;
   localparam logic [5:0] OFF_HELD_TICKS = 6'h1C;
   localparam logic [5:0] OFF_PULSE_TICKS = 6'h20;
   localparam logic [5:0] OFF_TICK_DIV = 6'h24;
   localparam logic [5:0] OFF_STATUS = 6'h28;
   localparam logic [5:0] OFF_COUNT = 6'h2C;
   // field positions
   localparam int DOOR_CFG_MODE_BIT = 0;
   localparam int DOOR_CFG_ENABLE_BIT = 1;
   localparam int DOOR_CFG_ALL_BIT = 2;
   localparam int DOOR_CFG_MASK_LSB = 8;
   localparam int CNT_CTRL_LOAD_BIT = 0;
   // reset values
   localparam logic [31:0] GATE_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] DOOR_CFG_RST = 32'h0000_1F02;
   localparam logic [15:0] CNT_MAX_RST = 16'hFFFF;
   localparam logic [15:0] CNT_PRELOAD_RST = 16'h0000;
   localparam logic [15:0] DURATION_RST = 16'h0001;
   // timebase: one tick per millisecond by default at 40 mhz
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
   localparam logic [15:0] CNT_TOP = 16'hFFFF;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// file: sim/aio_monitor.sv
// checker: port-level assertions for the advanced i/o block
`timescale 1ns/10ps
`default_nettype none
module aio_monitor #(
   parameter int N_GATE = 7,
   parameter int N_DOOR = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [N_GATE-1:0] gate_in,
   input wire logic and_out,
   input wire logic xor_out,
   input wire logic nand_out,
   input wire logic door_all,
   input wire logic [N_DOOR-1:0] door_lock,
   input wire logic cnt_up,
   input wire logic cnt_down,
   input wire logic cnt_clear,
   input wire logic cnt_nonzero,
   input wire logic exit_hold,
   input wire logic exit_contact,
   input wire logic exit_strike,
   input wire logic exit_forced,
   input wire logic pulse_in,
   input wire logic pulse_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // bus answers one cycle after a request and the answer stands one cycle
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   bus_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   // all inputs low keeps and/xor low, all inputs high keeps nand/xor low; and and nand never high together
   gate_low_a: assert property ($past(gate_in) == '0 |-> !and_out && !xor_out)
      else $error("and or xor high with all inputs low");
   gate_high_a: assert property (&$past(gate_in) |-> !nand_out && !xor_out)
      else $error("nand or xor high with all inputs high");
   gate_excl_a: assert property (!(and_out && nand_out))
      else $error("and and nand high together");
   // at most one door free while any other is locked
   door_one_a: assert property (
      door_lock != '0 |-> $countones(~door_lock) <= 1)
      else $error("more than one door unlocked");
   door_all_a: assert property (door_all [*2] |-> &door_lock)
      else $error("activate-all did not lock every door");
   cnt_clr_a: assert property ($rose(cnt_clear) |-> ##[1:2] !cnt_nonzero)
      else $error("counter clear left count nonzero");
   cnt_up_a: assert property (
      $rose(cnt_up) && !cnt_down && !cnt_clear |-> ##[1:2] cnt_nonzero)
      else $error("count up left count at zero");
   strike_hold_a: assert property (exit_hold [*2] |-> exit_strike)
      else $error("strike low while hold active");
   forced_contact_a: assert property (exit_forced |-> $past(exit_contact))
      else $error("forced-open high with contact low");
   pulse_edge_a: assert property ($rose(pulse_out) |-> $past(pulse_in))
      else $error("one-shot fired without input");
endmodule
`default_nettype wire

// file: sim/field_model.sv
// partner model: door contacts, exit buttons, card readers and event sources
`timescale 1ns/10ps
`default_nettype none
module field_model (
   input wire logic clk,
   output logic [6:0] gate_in,
   output logic [4:0] door_in,
   output logic cnt_up,
   output logic cnt_down,
   output logic cnt_clear,
   output logic exit_request,
   output logic exit_hold,
   output logic exit_contact,
   output logic pulse_in
);
   // every line idles low; levels move only just after a clock edge
   initial begin
      gate_in = 7'h00;
      door_in = 5'h00;
      {cnt_up, cnt_down, cnt_clear} = 3'h0;
      {exit_request, exit_hold, exit_contact, pulse_in} = 4'h0;
   end
   task automatic set_gates(input logic [6:0] v);
      @(posedge clk);
      gate_in <= v;
   endtask
   task automatic set_doors(input logic [4:0] v);
      @(posedge clk);
      door_in <= v;
   endtask
   // one-cycle event pulse; edge detection needs only a single high sample
   task automatic count(input logic [2:0] v);
      @(posedge clk);
      {cnt_up, cnt_down, cnt_clear} <= v;
      @(posedge clk);
      {cnt_up, cnt_down, cnt_clear} <= 3'h0;
   endtask
   task automatic set_exit(input logic [2:0] v);
      @(posedge clk);
      {exit_request, exit_hold, exit_contact} <= v;
   endtask
   task automatic set_pulse(input logic v);
      @(posedge clk);
      pulse_in <= v;
   endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// testbench: register access and function scenarios for the advanced i/o block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic door_all = 1'b0;
   logic door_enable = 1'b1;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic [31:0] r;
   logic avs_waitrequest, and_out, xor_out, nand_out, cnt_nonzero, cnt_at_max;
   logic exit_strike, exit_forced, exit_held, pulse_out;
   logic [4:0] door_lock;
   wire logic [6:0] gate_in;
   wire logic [4:0] door_in;
   wire logic cnt_up, cnt_down, cnt_clear, exit_request, exit_hold, exit_contact, pulse_in;
   int checks = 0;
   int miscompares = 0;
   initial begin
      forever #12.5 clk = ~clk;
   end
   // short tick divider keeps every timed duration to a few cycles
   aio_logic #(.TICK_DIV_RST(2)) dut_u (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .gate_in,
      .and_out, .xor_out, .nand_out, .door_in, .door_enable, .door_all, .door_lock,
      .cnt_up, .cnt_down, .cnt_clear, .cnt_nonzero, .cnt_at_max, .exit_request, .exit_hold,
      .exit_contact, .exit_strike, .exit_forced, .exit_held, .pulse_in, .pulse_out);
   field_model field_u (.clk, .gate_in, .door_in, .cnt_up, .cnt_down, .cnt_clear,
      .exit_request, .exit_hold, .exit_contact, .pulse_in);
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one avalon access: hold everything until waitrequest is seen low
   task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
         end_sim();
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      bus(aio_pkg::OFF_DOOR_CFG, 1'b0, 32'h0000_0000);
      chk(r, aio_pkg::DOOR_CFG_RST);
      bus(6'h3C, 1'b0, 32'h0000_0000);
      chk(r, aio_pkg::UNMAPPED_READ);
      // three gate inputs enabled; the four disabled ones sit high to expose masking
      bus(aio_pkg::OFF_GATE_CFG, 1'b1, 32'h0000_0007);
      // only lane 1 may land; the enables in lane 0 must survive
      avs_byteenable <= 4'h2;
      bus(aio_pkg::OFF_GATE_CFG, 1'b1, 32'hFFFF_7F00);
      avs_byteenable <= 4'hF;
      bus(aio_pkg::OFF_GATE_CFG, 1'b0, 32'h0000_0000);
      chk(r, 32'h0000_7F07);
      for (int i = 0; i < 8; i++) begin
         field_u.set_gates({4'hF, i[2:0]});
         cyc(3);
         chk({and_out, nand_out, xor_out},
            {&i[2:0], ~&i[2:0], i[2:0] != 0 && i[2:0] != 7});
      end
      $display("test gates done");
      field_u.set_doors(5'h01);
      cyc(3);
      chk(door_lock, 5'h1E);
      field_u.set_doors(5'h03);
      cyc(3);
      chk(door_lock, 5'h1E);
      field_u.set_doors(5'h01);
      field_u.set_doors(5'h00);
      cyc(3);
      chk(door_lock, 5'h00);
      door_all <= 1'b1;
      cyc(3);
      chk(door_lock, 5'h1F);
      door_all <= 1'b0;
      field_u.set_doors(5'h10);
      cyc(3);
      chk(door_lock, 5'h0F);
      field_u.set_doors(5'h00);
      bus(aio_pkg::OFF_DOOR_CFG, 1'b1, 32'h0000_1F03);
      cyc(3);
      chk(door_lock, 5'h1F);
      field_u.set_doors(5'h04);
      cyc(3);
      chk(door_lock, 5'h1B);
      field_u.set_doors(5'h14);
      cyc(3);
      chk(door_lock, 5'h1B);
      field_u.set_doors(5'h10);
      cyc(3);
      chk(door_lock, 5'h1F);
      field_u.set_doors(5'h00);
      // pin and config enable both low: grants must be ignored
      door_enable <= 1'b0;
      bus(aio_pkg::OFF_DOOR_CFG, 1'b1, 32'h0000_1F01);
      field_u.set_doors(5'h04);
      cyc(3);
      chk(door_lock, 5'h1F);
      field_u.set_doors(5'h00);
      door_enable <= 1'b1;
      field_u.set_doors(5'h04);
      cyc(3);
      chk(door_lock, 5'h1B);
      field_u.set_doors(5'h00);
      $display("test doors done");
      bus(aio_pkg::OFF_CNT_MAX, 1'b1, 32'h0000_0003);
      for (int i = 1; i <= 3; i++) begin
         field_u.count(3'h4);
         cyc(2);
         chk({cnt_at_max, cnt_nonzero}, {i == 3, 1'b1});
      end
      field_u.count(3'h2);
      cyc(2);
      chk({cnt_at_max, cnt_nonzero}, 2'h1);
      bus(aio_pkg::OFF_COUNT, 1'b0, 32'h0000_0000);
      chk(r, 32'h0000_0002);
      field_u.count(3'h1);
      cyc(2);
      chk({cnt_at_max, cnt_nonzero}, 2'h0);
      field_u.count(3'h2);
      cyc(2);
      bus(aio_pkg::OFF_COUNT, 1'b0, 32'h0000_0000);
      chk(r, 32'h0000_0000);
      bus(aio_pkg::OFF_CNT_PRELOAD, 1'b1, 32'h0000_FFFF);
      bus(aio_pkg::OFF_CNT_CTRL, 1'b1, 32'h0000_0001);
      field_u.count(3'h4);
      cyc(2);
      bus(aio_pkg::OFF_COUNT, 1'b0, 32'h0000_0000);
      chk(r, 32'h0000_FFFF);
      chk(cnt_at_max, 1'h1);
      $display("test counter done");
      bus(aio_pkg::OFF_STRIKE_TICKS, 1'b1, 32'h0000_0003);
      bus(aio_pkg::OFF_ALARM_TICKS, 1'b1, 32'h0000_0004);
      bus(aio_pkg::OFF_HELD_TICKS, 1'b1, 32'h0000_0003);
      bus(aio_pkg::OFF_PULSE_TICKS, 1'b1, 32'h0000_0003);
      field_u.set_exit(3'h4);
      cyc(3);
      chk(exit_strike, 1'h1);
      field_u.set_exit(3'h0);
      cyc(12);
      chk(exit_strike, 1'h0);
      field_u.set_exit(3'h2);
      cyc(3);
      field_u.set_exit(3'h6);
      cyc(20);
      chk(exit_strike, 1'h1);
      field_u.set_exit(3'h0);
      cyc(3);
      chk(exit_strike, 1'h0);
      // a contact blip shorter than the alarm delay must pass unnoticed
      field_u.set_exit(3'h1);
      cyc(2);
      field_u.set_exit(3'h0);
      cyc(12);
      chk(exit_forced, 1'h0);
      field_u.set_exit(3'h1);
      cyc(20);
      chk(exit_forced, 1'h1);
      field_u.set_exit(3'h0);
      cyc(3);
      chk(exit_forced, 1'h0);
      field_u.set_exit(3'h5);
      cyc(8);
      chk(exit_held, 1'h0);
      cyc(32);
      chk(exit_held, 1'h1);
      field_u.set_exit(3'h0);
      cyc(3);
      chk(exit_held, 1'h0);
      $display("test exit door done");
      // input stays high: the output must still end after its fixed time
      field_u.set_pulse(1'b1);
      cyc(3);
      chk(pulse_out, 1'h1);
      cyc(12);
      chk(pulse_out, 1'h0);
      field_u.set_pulse(1'b0);
      $display("test one-shot done");
      bus(aio_pkg::OFF_TICK_DIV, 1'b0, 32'h0000_0000);
      chk(r, 32'h0000_0002);
      // idle exit, man-trap doors locked, all gates high, count saturated above max
      bus(aio_pkg::OFF_STATUS, 1'b0, 32'h0000_0000);
      chk(r, 32'h0000_019F);
      $display("test registers done");
      end_sim();
   end
endmodule
bind aio_logic aio_monitor #(.N_GATE(N_GATE), .N_DOOR(N_DOOR)) mon_u (.clk, .rst_n, .avs_read,
   .avs_write, .avs_waitrequest, .gate_in, .and_out, .xor_out, .nand_out, .door_all, .door_lock,
   .cnt_up, .cnt_down, .cnt_clear, .cnt_nonzero, .exit_hold, .exit_contact, .exit_strike,
   .exit_forced, .pulse_in, .pulse_out);
`default_nettype wire
